// ===== rtl/sdl_pkg.sv
package sdl_pkg;
    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_STATUS = 8'h01;
    localparam logic [7:0] REG_LOSS_CTL = 8'h05;
    localparam logic [7:0] REG_RESERVED_A_A = 8'h06;
    localparam logic [7:0] REG_RESERVED_A_B = 8'h07;
    localparam logic [7:0] REG_CMP_TEST = 8'h08;
    localparam logic [7:0] REG_POS_COUNT = 8'h0a;
    localparam logic [7:0] REG_NEG_COUNT = 8'h0b;
    // ==========================================================
    // reset values
    localparam logic [7:0] LOSS_CTL_RST = 8'h02;
    localparam logic [7:0] RESERVED_A_RST = 8'h00;
    localparam logic [7:0] CMP_TEST_RST = 8'h00;
    // ==========================================================
    // field positions of the signal loss control register
    localparam int FORCE_INACT_BIT = 6;
    localparam int FORCE_ACT_BIT = 5;
    localparam int GATE_BIT = 4;
    localparam int MUTE_SEL_BIT = 3;
    localparam int THR_HI = 2;
    // compare command field and codes
    localparam int CMD_HI = 7;
    localparam int CMD_LO = 5;
    localparam logic [2:0] CMD_LIVE_MAX = 3'h0;
    localparam logic [2:0] CMD_CAP_POS = 3'h1;
    localparam logic [2:0] CMD_CAP_NEG = 3'h2;
    localparam logic [2:0] CMD_MIN_PRESET = 3'h5;
    localparam logic [4:0] PEAK_MAX_START = 5'h00;
    localparam logic [4:0] PEAK_MIN_START = 5'h1f;
    // ==========================================================
    // management bus
    localparam logic [6:0] DEV_ADDR = 7'h2a; // arbitrary value
    localparam logic [3:0] BYTE_BITS = 4'h8;
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_REG = 9'h008,
        ST_REG_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } sdl_state_t;
endpackage

// ===== rtl/sdl_ctrl.sv
// Contract
// R01: force-inactive bit makes signal loss act as always present for output.
// R02: force-active bit forbids any mute or offset, whatever the input.
// R03: forcing bits never alter the readable signal-present status bit.
// R04: enable pin low powers the output drivers down unconditionally.
// R05: with gating and enable high, no signal powers down; else power-down bit.
// R06: without gating, power state follows only power-down bit and enable pin.
// R07: on signal loss mute-select 0 inserts offset, 1 mutes the channel.
// R08: with valid input present, neither mute nor offset is applied; the code still applies one while force-inactive is set.
// R09: threshold is bits 2:0 (reset 010) joined with the separate low bit.
// R10: software writes zeros to the two reserved registers.
// R11: compare code 000 zeroes compare value, shows live counts, max mode.
// R12: code 001 shows counter 0 peak; code 010 shows counter 1 peak.
// R13: code 101 presets compare value to 1fh and tracks minimum.
// R14: software issues no reserved compare codes.
// R15: software writes zero to reserved bits of both control registers.
// R16: status bit reads 1 with valid input signal, 0 without.
// R17: power-down bit with enable high powers the output stage down.
// R18: counter readbacks return live value or captured peak per command.
// R19: a register write steers the outputs right after it completes.
`timescale 1ns/1ps
module sdl_ctrl
    import sdl_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // management bus pins
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // analog side and pins
    input wire logic input_signal_present,
    input wire logic enable_pin,
    input wire logic power_down_bit,
    input wire logic standard_rate_threshold_low_bit,
    input wire logic [4:0] positive_fault_counter,
    input wire logic [4:0] negative_fault_counter,
    // output stage control
    output logic output_power_down,
    output logic channel_mute,
    output logic offset_insert,
    output logic [3:0] standard_rate_fault_threshold
);
    // ==========================================================
    // pin synchronisers
    logic [1:0] scl_s, sda_s, pres_s, en_s;
    logic scl_d, sda_d;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            scl_s <= 2'h3;
            sda_s <= 2'h3;
            pres_s <= 2'h0;
            en_s <= 2'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_s <= {scl_s[0], scl};
            sda_s <= {sda_s[0], sda_in};
            pres_s <= {pres_s[0], input_signal_present};
            en_s <= {en_s[0], enable_pin};
            scl_d <= scl_s[1];
            sda_d <= sda_s[1];
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop, pres, en;
    assign scl_rise = scl_s[1] & ~scl_d;
    assign scl_fall = ~scl_s[1] & scl_d;
    assign bus_start = scl_s[1] & scl_d & sda_d & ~sda_s[1];
    assign bus_stop = scl_s[1] & scl_d & ~sda_d & sda_s[1];
    assign pres = pres_s[1];
    assign en = en_s[1];

    // ==========================================================
    // registers and read mux
    logic [7:0] loss_ctl_r, reserved_a_a_r, reserved_a_b_r, cmp_test_r;
    logic [4:0] peak_pos_r, peak_neg_r;
    logic min_mode_r;
    logic [7:0] ptr_r, shreg_r, rd_data;
    logic wr_en_r;
    logic [2:0] cmd;
    logic [4:0] pos_view, neg_view;
    assign cmd = cmp_test_r[CMD_HI:CMD_LO];
    // R18: live or peak readback
    assign pos_view = (cmd == CMD_CAP_POS) ? peak_pos_r : positive_fault_counter;
    assign neg_view = (cmd == CMD_CAP_NEG) ? peak_neg_r : negative_fault_counter;
    always_comb begin
        rd_data = 8'h00;
        case (ptr_r)
            // R03: status shows true input
            // R16: one when signal present
            REG_STATUS: rd_data = {7'h00, pres};
            REG_LOSS_CTL: rd_data = loss_ctl_r;
            REG_RESERVED_A_A: rd_data = reserved_a_a_r;
            REG_RESERVED_A_B: rd_data = reserved_a_b_r;
            REG_CMP_TEST: rd_data = cmp_test_r;
            REG_POS_COUNT: rd_data = {3'h0, pos_view};
            REG_NEG_COUNT: rd_data = {3'h0, neg_view};
            default: rd_data = 8'h00;
        endcase
    end

    // ==========================================================
    // bus slave state machine
    sdl_state_t state_r;
    logic [3:0] cnt_r;
    logic rw_r, nack_r;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            ptr_r <= 8'h00;
            shreg_r <= 8'h00;
            sda_oe_n <= 1'b1;
            wr_en_r <= 1'b0;
        end else begin
            wr_en_r <= 1'b0;
            if (bus_stop) begin
                state_r <= ST_IDLE;
                sda_oe_n <= 1'b1;
            end else if (bus_start) begin
                state_r <= ST_ADDR;
                cnt_r <= 4'h0;
                sda_oe_n <= 1'b1;
            end else if (scl_rise) begin
                case (state_r)
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        shreg_r <= {shreg_r[6:0], sda_s[1]};
                        cnt_r <= cnt_r + 4'h1;
                    end
                    ST_RDATA_ACK: nack_r <= sda_s[1];
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_r)
                    ST_ADDR: begin
                        if (cnt_r == BYTE_BITS) begin
                            if (shreg_r[7:1] == DEV_ADDR) begin
                                rw_r <= shreg_r[0];
                                sda_oe_n <= 1'b0;
                                state_r <= ST_ADDR_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            shreg_r <= rd_data;
                            sda_oe_n <= rd_data[7];
                            state_r <= ST_RDATA;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state_r <= ST_REG;
                        end
                    end
                    ST_REG: begin
                        if (cnt_r == BYTE_BITS) begin
                            ptr_r <= shreg_r;
                            sda_oe_n <= 1'b0;
                            state_r <= ST_REG_ACK;
                        end
                    end
                    ST_WDATA: begin
                        if (cnt_r == BYTE_BITS) begin
                            wr_en_r <= 1'b1;
                            sda_oe_n <= 1'b0;
                            state_r <= ST_WDATA_ACK;
                        end
                    end
                    ST_REG_ACK, ST_WDATA_ACK: begin
                        if (state_r == ST_WDATA_ACK) begin
                            ptr_r <= ptr_r + 8'h01;
                        end
                        sda_oe_n <= 1'b1;
                        cnt_r <= 4'h0;
                        state_r <= ST_WDATA;
                    end
                    ST_RDATA: begin
                        if (cnt_r == BYTE_BITS - 4'h1) begin
                            sda_oe_n <= 1'b1;
                            state_r <= ST_RDATA_ACK;
                        end else begin
                            shreg_r <= {shreg_r[6:0], 1'b0};
                            sda_oe_n <= shreg_r[6];
                            cnt_r <= cnt_r + 4'h1;
                        end
                    end
                    ST_RDATA_ACK: begin
                        if (nack_r) begin
                            state_r <= ST_IDLE;
                        end else begin
                            ptr_r <= ptr_r + 8'h01;
                            state_r <= ST_ADDR_ACK;
                            rw_r <= 1'b1;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
    // open drain: only ever pulls low
    assign sda_out = 1'b0;

    // ==========================================================
    // register writes
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            loss_ctl_r <= LOSS_CTL_RST;
            reserved_a_a_r <= RESERVED_A_RST;
            reserved_a_b_r <= RESERVED_A_RST;
            cmp_test_r <= CMP_TEST_RST;
        end else if (wr_en_r) begin
            // R19: write takes effect at once
            case (ptr_r)
                REG_LOSS_CTL: loss_ctl_r <= shreg_r;
                REG_RESERVED_A_A: reserved_a_a_r <= shreg_r;
                REG_RESERVED_A_B: reserved_a_b_r <= shreg_r;
                REG_CMP_TEST: cmp_test_r <= shreg_r;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // peak capture
    logic cmd_wr;
    logic [2:0] wr_cmd;
    assign cmd_wr = wr_en_r && (ptr_r == REG_CMP_TEST);
    assign wr_cmd = shreg_r[CMD_HI:CMD_LO];
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            peak_pos_r <= PEAK_MAX_START;
            peak_neg_r <= PEAK_MAX_START;
            min_mode_r <= 1'b0;
        end else if (cmd_wr && wr_cmd == CMD_LIVE_MAX) begin
            // R11: zero and max mode
            peak_pos_r <= PEAK_MAX_START;
            peak_neg_r <= PEAK_MAX_START;
            min_mode_r <= 1'b0;
        end else if (cmd_wr && wr_cmd == CMD_MIN_PRESET) begin
            // R13: preset and min mode
            peak_pos_r <= PEAK_MIN_START;
            peak_neg_r <= PEAK_MIN_START;
            min_mode_r <= 1'b1;
        end else begin
            // R12: track selected counter
            if (cmd == CMD_CAP_POS && ((positive_fault_counter > peak_pos_r) ^ min_mode_r)
                && positive_fault_counter != peak_pos_r) begin
                peak_pos_r <= positive_fault_counter;
            end
            if (cmd == CMD_CAP_NEG && ((negative_fault_counter > peak_neg_r) ^ min_mode_r)
                && negative_fault_counter != peak_neg_r) begin
                peak_neg_r <= negative_fault_counter;
            end
        end
    end

    // ==========================================================
    // output stage control
    logic loss_eff;
    always_comb begin
        // R02: force-active wins
        if (loss_ctl_r[FORCE_ACT_BIT]) begin
            loss_eff = 1'b0;
        // R01: forced loss
        end else if (loss_ctl_r[FORCE_INACT_BIT]) begin
            loss_eff = 1'b1;
        // R08: normal when present
        end else begin
            loss_eff = ~pres;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            channel_mute <= 1'b0;
            offset_insert <= 1'b0;
        end else begin
            // R07: mute or offset
            channel_mute <= loss_eff & loss_ctl_r[MUTE_SEL_BIT];
            offset_insert <= loss_eff & ~loss_ctl_r[MUTE_SEL_BIT];
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            output_power_down <= 1'b1;
        end else begin
            // R04: R05: R06: R17: power gating
            output_power_down <= ~en | power_down_bit | (loss_ctl_r[GATE_BIT] & ~pres);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            standard_rate_fault_threshold <= {LOSS_CTL_RST[THR_HI:0], 1'b1};
        end else begin
            // R09: threshold join
            standard_rate_fault_threshold <= {loss_ctl_r[THR_HI:0],
                                              standard_rate_threshold_low_bit};
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    force_active_a: assert property (loss_ctl_r[FORCE_ACT_BIT] |=> !channel_mute && !offset_insert) // R02
        else $error("mute or offset while forced active");
    force_inact_a: assert property (!loss_ctl_r[FORCE_ACT_BIT] && loss_ctl_r[FORCE_INACT_BIT] // R01
        |=> (channel_mute != offset_insert) && channel_mute == $past(loss_ctl_r[MUTE_SEL_BIT]))
        else $error("forced loss not applied");
    loss_select_a: assert property (!loss_ctl_r[FORCE_ACT_BIT] && !pres // R07
        |=> channel_mute == $past(loss_ctl_r[MUTE_SEL_BIT]) && offset_insert != channel_mute)
        else $error("wrong loss action");
    normal_run_a: assert property (pres && !loss_ctl_r[FORCE_INACT_BIT] // R08
        |=> !channel_mute && !offset_insert)
        else $error("action applied with signal present");
    status_true_a: assert property (ptr_r == REG_STATUS |-> rd_data[0] == pres) // R03
        else $error("status differs from input");
    enable_low_a: assert property (!en |=> output_power_down) // R04
        else $error("enable low did not power down");
    gate_loss_a: assert property (en && loss_ctl_r[GATE_BIT] && !pres |=> output_power_down) // R05
        else $error("gated loss did not power down");
    pd_follow_a: assert property ((en && (!loss_ctl_r[GATE_BIT] || pres)) // R06
        |=> output_power_down == $past(power_down_bit))
        else $error("power state not from bit");
    cmd_zero_a: assert property (cmd_wr && wr_cmd == CMD_LIVE_MAX // R11
        |=> peak_pos_r == PEAK_MAX_START && peak_neg_r == PEAK_MAX_START && !min_mode_r
        && pos_view == positive_fault_counter && neg_view == negative_fault_counter)
        else $error("code 000 effect wrong");
    cmd_min_a: assert property (cmd_wr && wr_cmd == CMD_MIN_PRESET // R13
        |=> peak_neg_r == PEAK_MIN_START && min_mode_r)
        else $error("code 101 effect wrong");
    write_now_a: assert property (wr_en_r && ptr_r == REG_LOSS_CTL // R19
        |=> loss_ctl_r == $past(shreg_r)
        ##1 standard_rate_fault_threshold[3:1] == $past(loss_ctl_r[THR_HI:0]))
        else $error("write not applied");
endmodule // sdl_ctrl

// ===== dv/sdl_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// management bus host: open drain, pulls sda low or releases it
module sdl_host_model
    import sdl_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // bus wires
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    int ack_errs = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // one quarter of a bus bit, well above the 4 cycle minimum phase
    task automatic wait_q();
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic start_c();
        sda_low = 1'b0;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    task automatic stop_c();
        sda_low = 1'b1;
        wait_q();
        scl = 1'b1;
        wait_q();
        sda_low = 1'b0;
        wait_q();
    endtask
    // one bus clock with sda already set
    task automatic pulse(output logic bit_v);
        wait_q();
        scl = 1'b1;
        wait_q();
        bit_v = sda_line;
        wait_q();
        scl = 1'b0;
        wait_q();
    endtask
    task automatic send_byte(input logic [7:0] b);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            sda_low = !b[i];
            pulse(v);
        end
        sda_low = 1'b0;
        pulse(v);
        if (v !== 1'b0) begin
            ack_errs++;
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start_c();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(a);
        send_byte(d);
        stop_c();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic v;
        start_c();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(a);
        start_c();
        send_byte({DEV_ADDR, 1'b1});
        sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(d[i]);
        end
        // single byte read ends with no acknowledge
        pulse(v);
        stop_c();
    endtask
endmodule // sdl_host_model

// ===== dv/sdl_ctrl_test.sv
`timescale 1ns/1ps
module sdl_ctrl_test;
    import sdl_pkg::*;
    typedef struct packed {
        logic [7:0] ctl;
        logic pres;
        logic en;
        logic pdb;
        logic lowb;
        logic [2:0] exp;
    } sdl_row_t;
    // ==========================================================
    // rows: control byte, pins, expected {power down, mute, offset}
    // control bit 7 always written as zero
    localparam sdl_row_t ROWS[11] = '{
        '{8'h08, 1'b0, 1'b1, 1'b0, 1'b1, 3'b010},
        '{8'h03, 1'b0, 1'b1, 1'b0, 1'b0, 3'b001},
        '{8'h0a, 1'b1, 1'b1, 1'b0, 1'b1, 3'b000},
        '{8'h48, 1'b1, 1'b1, 1'b0, 1'b1, 3'b010},
        '{8'h20, 1'b0, 1'b1, 1'b0, 1'b1, 3'b000},
        '{8'h10, 1'b0, 1'b1, 1'b0, 1'b1, 3'b101},
        '{8'h14, 1'b1, 1'b1, 1'b1, 1'b0, 3'b100},
        '{8'h14, 1'b1, 1'b1, 1'b0, 1'b0, 3'b000},
        '{8'h07, 1'b1, 1'b1, 1'b1, 1'b1, 3'b100},
        '{8'h0f, 1'b1, 1'b0, 1'b0, 1'b1, 3'b100},
        '{8'h38, 1'b0, 1'b1, 1'b0, 1'b0, 3'b100}
    };
    logic ref_clk, srst, scl, sda_low, sda_out, sda_oe_n, present, enable_pin, pd_bit, low_bit;
    logic output_power_down, channel_mute, offset_insert;
    logic [3:0] threshold;
    logic [4:0] pos_cnt, neg_cnt;
    logic [7:0] rd;
    int mismatches = 0;
    int num_checks = 0;
    // released sda floats high through the pull-up
    wire sda_line = sda_low ? 1'b0 : (!sda_oe_n ? sda_out : 1'b1);
    sdl_ctrl dut_u (.ref_clk(ref_clk), .srst(srst), .scl(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .input_signal_present(present),
        .enable_pin(enable_pin), .power_down_bit(pd_bit),
        .standard_rate_threshold_low_bit(low_bit), .positive_fault_counter(pos_cnt),
        .negative_fault_counter(neg_cnt), .output_power_down(output_power_down),
        .channel_mute(channel_mute), .offset_insert(offset_insert),
        .standard_rate_fault_threshold(threshold));
    sdl_host_model host_u (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (6) @(negedge ref_clk);
    endtask
    // ==========================================================
    // watchdog
    initial begin
        repeat (95000) @(posedge ref_clk);
        mismatches++;
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        srst = 1'b1;
        present = 1'b1;
        enable_pin = 1'b1;
        pd_bit = 1'b0;
        low_bit = 1'b1;
        pos_cnt = 5'h05;
        neg_cnt = 5'h09;
        repeat (16) @(negedge ref_clk);
        check("reset_stage", {1'b0, output_power_down, channel_mute, offset_insert, threshold},
            8'h45);
        srst = 1'b0;
        repeat (4) @(negedge ref_clk);
        foreach (ROWS[i]) begin
            present = ROWS[i].pres;
            enable_pin = ROWS[i].en;
            pd_bit = ROWS[i].pdb;
            low_bit = ROWS[i].lowb;
            host_u.write_reg(REG_LOSS_CTL, ROWS[i].ctl);
            settle();
            check("stage", {1'b0, output_power_down, channel_mute, offset_insert, threshold},
                {1'b0, ROWS[i].exp, ROWS[i].ctl[2:0], ROWS[i].lowb});
            host_u.read_reg(REG_STATUS, rd);
            check("status", rd, {7'h0, ROWS[i].pres});
            host_u.read_reg(REG_LOSS_CTL, rd);
            check("loss_ctl", rd, ROWS[i].ctl);
        end
        host_u.write_reg(REG_RESERVED_A_A, 8'h00);
        host_u.read_reg(REG_RESERVED_A_A, rd);
        check("reserved_a_a", rd, RESERVED_A_RST);
        host_u.read_reg(REG_RESERVED_A_B, rd);
        check("reserved_a_b", rd, RESERVED_A_RST);
        // compare commands, reserved codes never issued: low bits zero
        host_u.write_reg(REG_CMP_TEST, 8'h00);
        host_u.read_reg(REG_POS_COUNT, rd);
        check("pos_live", rd, 8'h05);
        host_u.read_reg(REG_NEG_COUNT, rd);
        check("neg_live", rd, 8'h09);
        host_u.write_reg(REG_CMP_TEST, 8'h20);
        pos_cnt = 5'h0c;
        settle();
        pos_cnt = 5'h03;
        host_u.read_reg(REG_POS_COUNT, rd);
        check("pos_max_peak", rd, 8'h0c);
        neg_cnt = 5'h02;
        host_u.write_reg(REG_CMP_TEST, 8'h40);
        neg_cnt = 5'h0e;
        settle();
        neg_cnt = 5'h02;
        host_u.read_reg(REG_NEG_COUNT, rd);
        check("neg_max_peak", rd, 8'h0e);
        host_u.write_reg(REG_CMP_TEST, 8'ha0);
        host_u.read_reg(REG_POS_COUNT, rd);
        check("pos_live_min", rd, 8'h03);
        pos_cnt = 5'h1a;
        host_u.write_reg(REG_CMP_TEST, 8'h20);
        pos_cnt = 5'h04;
        settle();
        pos_cnt = 5'h0a;
        host_u.read_reg(REG_POS_COUNT, rd);
        check("pos_min_peak", rd, 8'h04);
        host_u.read_reg(8'h0f, rd);
        check("unmapped", rd, 8'h00);
        check("bus_ack", host_u.ack_errs[7:0], 8'h00);
        print_verdict();
    end
endmodule // sdl_ctrl_test
